// ===== rtl/crr_ctrl.sv
// restart, reset gating and peripheral core reset control with apb access
// Notes on behaviour
// - with control bit 0 set, a port 92 restart raises smi instead.
// - with control bit 0 clear, a port 92 restart resets the cpu.
// - control bit 1 turns the port 92 password protection on.
// - once protected, clearing bit 1 does not lift the protection.
// - bit 3 clear resets the cpu only out of hold, set only in hold.
// - bit 4 clear lets link code 101 restart the cpu, set blocks it.
// - bit 5 lets the mouse interrupt flop drive irq12 open collector.
// - bit 7 clear resets the core while power good is low, set keeps it.
// - bit 7 is cleared by battery reset, not by power good.
// - power good and battery reset both low always reset the core.
// - battery reset is ignored while power good is high.
`timescale 1ns/1ps
`include "crr_params.svh"
module crr_ctrl (
	input  wire logic                   CORE_CLK_I,
	input  wire logic                   RST_I,
	input  wire logic                   PSEL_I,
	input  wire logic                   PENABLE_I,
	input  wire logic                   PWRITE_I,
	input  wire logic [`CRR_ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]            PWDATA_I,
	output logic      [31:0]            PRDATA_O,
	output logic                        PREADY_O,
	output logic                        PSLVERR_O,
	input  wire logic                   PORT92_RESTART_I,
	input  wire logic                   LINK_CODE_VALID_I,
	input  wire logic [2:0]             LINK_CODE_I,
	input  wire logic                   MOUSE_IRQ_SET_I,
	input  wire logic                   MOUSE_IRQ_CLR_I,
	input  wire logic                   CPU_HOLD_I,
	input  wire logic                   POWER_GOOD_IN_I,
	input  wire logic                   BATTERY_RESET_N_I,
	output logic                        CPU_RESET_O,
	output logic                        SMI_O,
	output logic                        PWD_LOCK_O,
	output logic                        IRQ12_O,
	output logic                        IRQ12_OE_O,
	output logic                        PERIPHERAL_CORE_RESET_O
);

	// ==========================================================
	// address decode
	function automatic crr_pkg::crr_sel_type reg_sel(
		input logic [`CRR_ADDR_W-1:0] addr
	);
		reg_sel = crr_pkg::SEL_NONE;
		if (addr == `CRR_OFS_CTRL) begin
			reg_sel = crr_pkg::SEL_CTRL;
		end else if (addr == `CRR_OFS_STAT) begin
			reg_sel = crr_pkg::SEL_STAT;
		end
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [2:0]                pin_raw;
	logic [2:0]                pin_s1;
	logic [2:0]                pin_s2;
	logic                      hold_s;
	logic                      pg_s;
	logic                      batt_n_s;

	assign pin_raw = {BATTERY_RESET_N_I, POWER_GOOD_IN_I, CPU_HOLD_I};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
				if (RST_I) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
				end
			end
		end
	endgenerate

	assign hold_s   = pin_s2[0];
	assign pg_s     = pin_s2[1];
	assign batt_n_s = pin_s2[2];

	// ==========================================================
	// declarations
	logic [7:0]                ctl;
	logic                      prot;
	logic                      core_rst;
	logic                      next_core_rst;
	logic                      batt_qual;
	logic                      wr_ctl;
	logic                      acc;
	logic                      p92_smi;
	logic                      p92_rst;
	logic                      code_rst;
	logic                      restart_req;
	logic                      gate_ok;
	logic                      mouse_ff;
	logic [`CRR_CNT_W-1:0]     cnt;
	crr_pkg::crr_state_type    state;
	crr_pkg::crr_state_type    next_state;

	localparam logic [`CRR_CNT_W-1:0] PULSE_LEN =
		`CRR_CNT_W'(`CRR_RST_CYCLES);

	// ==========================================================
	// apb slave, answers one cycle into the access phase
	assign acc    = PSEL_I & PENABLE_I;
	assign wr_ctl = acc & PREADY_O & PWRITE_I &
		(reg_sel(PADDR_I) == crr_pkg::SEL_CTRL);

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end else begin
			PREADY_O  <= acc & ~PREADY_O;
			PSLVERR_O <= acc & ~PREADY_O &
				(reg_sel(PADDR_I) == crr_pkg::SEL_NONE);
			PRDATA_O  <= 32'h0000_0000;
			if (acc && !PREADY_O && !PWRITE_I) begin
				unique case (reg_sel(PADDR_I))
				crr_pkg::SEL_CTRL: begin
					PRDATA_O <= {24'h00_0000, ctl};
				end
				crr_pkg::SEL_STAT: begin
					PRDATA_O <= {23'h00_0000, hold_s, batt_n_s,
						pg_s, mouse_ff, state, prot, core_rst,
						CPU_RESET_O};
				end
				crr_pkg::SEL_NONE: begin
					PRDATA_O <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// control register
	assign batt_qual = ~batt_n_s & ~pg_s;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctl <= `CRR_CTRL_RESET;
		end else if (batt_qual) begin
			ctl <= `CRR_CTRL_RESET;
		end else if (core_rst) begin
			// core bits follow the core reset, bit 7 does not
			ctl <= ctl & `CRR_CTRL_KEEP;
		end else if (wr_ctl) begin
			ctl <= PWDATA_I[7:0] & `CRR_CTRL_WMASK;
		end
	end

	// ==========================================================
	// password protection, cleared only by core reset
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prot <= 1'b0;
		end else if (core_rst) begin
			prot <= 1'b0;
		end else if (ctl[`CRR_B_PWD_EN]) begin
			prot <= 1'b1;
		end
	end

	assign PWD_LOCK_O = prot;

	// ==========================================================
	// peripheral core reset
	always_comb begin
		next_core_rst = 1'b0;
		if (!pg_s && !ctl[`CRR_B_CORE_KEEP]) begin
			next_core_rst = 1'b1;
		end
		if (batt_qual) begin
			next_core_rst = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			core_rst <= 1'b1;
		end else begin
			core_rst <= next_core_rst;
		end
	end

	assign PERIPHERAL_CORE_RESET_O = core_rst;

	// ==========================================================
	// restart sources
	assign p92_smi  = PORT92_RESTART_I & ctl[`CRR_B_P92_SMI];
	assign p92_rst  = PORT92_RESTART_I & ~ctl[`CRR_B_P92_SMI];
	assign code_rst = LINK_CODE_VALID_I &
		(LINK_CODE_I == `CRR_CODE_RESTART) &
		~ctl[`CRR_B_ALT_DIS];
	assign restart_req = (p92_rst | code_rst) & ~core_rst;
	assign gate_ok = ctl[`CRR_B_HOLD_MODE] ? hold_s : ~hold_s;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SMI_O <= 1'b0;
		end else begin
			SMI_O <= p92_smi & ~core_rst;
		end
	end

	// ==========================================================
	// cpu reset sequencer
	always_comb begin
		next_state = state;
		unique case (state)
		crr_pkg::ST_IDLE: begin
			if (restart_req) begin
				next_state = crr_pkg::ST_WAIT;
			end
		end
		crr_pkg::ST_WAIT: begin
			if (gate_ok) begin
				next_state = crr_pkg::ST_PULSE;
			end
		end
		crr_pkg::ST_PULSE: begin
			if (!gate_ok) begin
				next_state = crr_pkg::ST_WAIT;
			end else if (cnt == `CRR_CNT_W'(1)) begin
				next_state = crr_pkg::ST_IDLE;
			end
		end
		default: begin
			next_state = crr_pkg::ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= crr_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cnt <= `CRR_CNT_W'(0);
		end else if (state == crr_pkg::ST_IDLE) begin
			cnt <= PULSE_LEN;
		end else if (next_state == crr_pkg::ST_PULSE &&
			state == crr_pkg::ST_PULSE) begin
			cnt <= cnt - `CRR_CNT_W'(1);
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			CPU_RESET_O <= 1'b0;
		end else begin
			CPU_RESET_O <= (next_state == crr_pkg::ST_PULSE);
		end
	end

	// ==========================================================
	// mouse interrupt flop and irq12 open collector
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			mouse_ff <= 1'b0;
		end else if (MOUSE_IRQ_SET_I) begin
			mouse_ff <= 1'b1;
		end else if (MOUSE_IRQ_CLR_I) begin
			mouse_ff <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ12_O    <= 1'b0;
			IRQ12_OE_O <= 1'b0;
		end else begin
			IRQ12_O    <= 1'b0;
			// pull low while the flop is clear, release to float high
			IRQ12_OE_O <= ctl[`CRR_B_IRQ12_EN] & ~mouse_ff;
		end
	end

	// ==========================================================
	// checks
	sequence s_p92_req;
		PORT92_RESTART_I && !core_rst;
	endsequence

	sequence s_code_req;
		LINK_CODE_VALID_I && LINK_CODE_I == `CRR_CODE_RESTART &&
		!core_rst;
	endsequence

	smi_on_disabled_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		s_p92_req and ctl[0] |=> SMI_O)
		else $error("port 92 restart with bit 0 set gave no smi");
	restart_direct_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		s_p92_req and !ctl[0] && state == crr_pkg::ST_IDLE |=>
		state == crr_pkg::ST_WAIT)
		else $error("port 92 restart did not start cpu reset");
	smi_only_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		SMI_O |-> $past(ctl[0]))
		else $error("smi raised with bit 0 clear");
	prot_sticky_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		prot && !core_rst |=> prot)
		else $error("password protection lifted without core reset");
	hold_gate_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		CPU_RESET_O |-> $past(ctl[3]) == $past(hold_s))
		else $error("cpu reset applied in the wrong hold state");
	link_code_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		s_code_req and ctl[4] && state == crr_pkg::ST_IDLE &&
		!PORT92_RESTART_I |=> state == crr_pkg::ST_IDLE)
		else $error("blocked link code started a cpu restart");
	irq_drive_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!ctl[5] |=> !IRQ12_OE_O && !IRQ12_O)
		else $error("irq12 driven while disabled");
	core_rst_pg_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!pg_s && !ctl[7] |=> core_rst)
		else $error("core not reset with power good low");
	core_rst_both_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		!pg_s && !batt_n_s |=> core_rst ##0 ctl == 8'h00)
		else $error("core or bit 7 not reset on battery reset");
	bit7_keep_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ctl[7] && batt_n_s && !wr_ctl |=> ctl[7])
		else $error("bit 7 lost without battery reset");
	batt_ignored_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		pg_s && !core_rst |=> !core_rst)
		else $error("core reset while power good high");
	rsvd_zero_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		ctl[2] == 1'b0 && ctl[6] == 1'b0)
		else $error("reserved control bit set");
	// full pulse is exactly 8 high, a gate loss cuts it shorter
	pulse_len_a: assert property (
		@(posedge CORE_CLK_I) disable iff (RST_I)
		$rose(CPU_RESET_O) |-> CPU_RESET_O [*8] ##1 !CPU_RESET_O
		or ##[1:8] !CPU_RESET_O)
		else $error("cpu reset pulse length wrong");

endmodule

// ===== shared/crr_params.svh
// offsets, field positions, reset values and timing for restart control
`ifndef CRR_PARAMS_SVH
`define CRR_PARAMS_SVH
`define CRR_ADDR_W         12
`define CRR_OFS_CTRL       12'h000
`define CRR_OFS_STAT       12'h004
`define CRR_CTRL_RESET     8'h00
`define CRR_CTRL_WMASK     8'hbb
`define CRR_CTRL_KEEP      8'h80
`define CRR_B_P92_SMI      0
`define CRR_B_PWD_EN       1
`define CRR_B_HOLD_MODE    3
`define CRR_B_ALT_DIS      4
`define CRR_B_IRQ12_EN     5
`define CRR_B_CORE_KEEP    7
`define CRR_CODE_RESTART   3'h5
`define CRR_CLK_NS         8
`define CRR_RST_PULSE_NS   64
`define CRR_RST_CYCLES ((`CRR_RST_PULSE_NS + `CRR_CLK_NS - 1) / `CRR_CLK_NS)
`define CRR_CNT_W          4
`endif

// ===== shared/crr_pkg.sv
// types for the restart and reset control block
package crr_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_PULSE = 2'b10
	} crr_state_type;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_CTRL = 2'b01,
		SEL_STAT = 2'b10
	} crr_sel_type;
endpackage

// ===== sim/crr_cpu_model.sv
// host cpu model: counts restart cycles and smi, enters hold on request
`timescale 1ns/1ps
module crr_cpu_model (
	input  wire logic       clk_i,
	input  wire logic       cpu_reset_i,
	input  wire logic       smi_i,
	input  wire logic       hold_req_i,
	input  wire logic       clr_i,
	output logic            hold_o,
	output logic [7:0]      reset_cycles_o,
	output logic [7:0]      smi_count_o
);
	// hold follows the request one cycle late, like a bus grant
	always_ff @(posedge clk_i) begin
		hold_o <= hold_req_i;
	end

	always_ff @(posedge clk_i) begin
		if (clr_i) begin
			reset_cycles_o <= 8'h00;
			smi_count_o    <= 8'h00;
		end else begin
			reset_cycles_o <= reset_cycles_o + {7'h00, cpu_reset_i};
			smi_count_o    <= smi_count_o + {7'h00, smi_i};
		end
	end
endmodule

// ===== sim/crr_ctrl_bench.sv
// self-checking bench for the restart and reset control block
`timescale 1ns/1ps
`include "crr_params.svh"
module crr_ctrl_bench;
	localparam logic [7:0] RC = 8'(`CRR_RST_CYCLES);
	logic        clk, rst, psel, penable, pwrite, p92, lvalid;
	logic        mset, mclr, pg, batt_n, hold_req, cnt_clr, hold;
	logic        pready, pslverr, cpu_rst, smi, lock, irq, irq_oe, core;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [2:0]  lcode;
	logic [7:0]  rcyc, scnt;
	logic [7:0]  row_w [3] = '{8'hff, 8'h44, 8'h00};
	logic [7:0]  row_r [3] = '{8'hbb, 8'h00, 8'h00};
	logic        rerr;
	int          num_errors, total_checks;

	crr_ctrl uut (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .PORT92_RESTART_I(p92),
		.LINK_CODE_VALID_I(lvalid), .LINK_CODE_I(lcode),
		.MOUSE_IRQ_SET_I(mset), .MOUSE_IRQ_CLR_I(mclr), .CPU_HOLD_I(hold),
		.POWER_GOOD_IN_I(pg), .BATTERY_RESET_N_I(batt_n),
		.CPU_RESET_O(cpu_rst), .SMI_O(smi), .PWD_LOCK_O(lock),
		.IRQ12_O(irq), .IRQ12_OE_O(irq_oe),
		.PERIPHERAL_CORE_RESET_O(core));

	crr_cpu_model cpu (.clk_i(clk), .cpu_reset_i(cpu_rst), .smi_i(smi),
		.hold_req_i(hold_req), .clr_i(cnt_clr), .hold_o(hold),
		.reset_cycles_o(rcyc), .smi_count_o(scnt));

	task automatic test_done;
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch time %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			test_done;
		end
	endtask

	// write control, fire one restart request, count the answer
	task automatic fire(input logic link, input logic [7:0] ctl,
		input logic [7:0] cyc, input logic [7:0] smis);
		apb(1'b1, `CRR_OFS_CTRL, {24'h0, ctl});
		@(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		p92 <= !link;
		lvalid <= link;
		@(posedge clk);
		p92 <= 1'b0;
		lvalid <= 1'b0;
		idle(16);
		chk({24'h0, rcyc}, {24'h0, cyc});
		chk({24'h0, scnt}, {24'h0, smis});
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		{psel, penable, pwrite, p92, lvalid, mset, mclr} = 7'h00;
		{hold_req, paddr, pwdata} = '0;
		{pg, batt_n, rst, cnt_clr, lcode} = {4'hf, `CRR_CODE_RESTART};
		idle(16);
		chk({30'h0, core, cpu_rst}, 32'h2);
		rst <= 1'b0;
		idle(6);
		apb(1'b0, `CRR_OFS_CTRL, 32'h0);
		chk(rdat, 32'h0);
		chk({31'h0, lock}, 32'h0);
		// status: power good and battery synced high, all else idle
		apb(1'b0, `CRR_OFS_STAT, 32'h0);
		chk(rdat, 32'h0000_00c0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `CRR_OFS_CTRL, {24'h0, row_w[i]});
			apb(1'b0, `CRR_OFS_CTRL, 32'h0);
			chk(rdat, {24'h0, row_r[i]});
			chk({31'h0, lock}, 32'h1);
		end
		apb(1'b0, 12'h008, 32'h0);
		chk({rerr, rdat[30:0]}, 32'h80000000);
		fire(1'b0, 8'h00, RC, 8'h00);
		fire(1'b0, 8'h01, 8'h00, 8'h01);
		fire(1'b1, 8'h00, RC, 8'h00);
		fire(1'b1, 8'h10, 8'h00, 8'h00);
		lcode <= 3'h3;
		fire(1'b1, 8'h00, 8'h00, 8'h00);
		for (int m = 0; m < 2; m++) begin
			// hold first in the blocking state, then in the allowed one
			hold_req <= !m[0];
			fire(1'b0, m[0] ? 8'h08 : 8'h00, 8'h00, 8'h00);
			hold_req <= m[0];
			idle(16);
			chk({24'h0, rcyc}, {24'h0, RC});
		end
		mclr <= 1'b1;
		apb(1'b1, `CRR_OFS_CTRL, 32'h20);
		mclr <= 1'b0;
		idle(2);
		chk({31'h0, irq_oe}, 32'h1);
		mset <= 1'b1;
		idle(1);
		mset <= 1'b0;
		idle(3);
		chk({30'h0, irq, irq_oe}, 32'h0);
		mclr <= 1'b1;
		apb(1'b1, `CRR_OFS_CTRL, 32'h00);
		mclr <= 1'b0;
		idle(3);
		chk({31'h0, irq_oe}, 32'h0);
		apb(1'b1, `CRR_OFS_CTRL, 32'h80);
		pg <= 1'b0;
		idle(6);
		chk({31'h0, core}, 32'h0);
		{pg, batt_n} <= 2'b10;
		idle(6);
		chk({31'h0, core}, 32'h0);
		apb(1'b0, `CRR_OFS_CTRL, 32'h0);
		chk(rdat, 32'h80);
		pg <= 1'b0;
		idle(6);
		chk({31'h0, core}, 32'h1);
		{pg, batt_n} <= 2'b11;
		idle(6);
		apb(1'b0, `CRR_OFS_CTRL, 32'h0);
		chk(rdat, 32'h0);
		pg <= 1'b0;
		idle(6);
		chk({31'h0, core}, 32'h1);
		pg <= 1'b1;
		idle(6);
		chk({31'h0, core}, 32'h0);
		test_done;
	end
endmodule
